// ===== core/ccpu_cap_if.sv
// link between the unit core and one capture channel
`timescale 1ns/1ps
interface ccpu_cap_if;
  logic [ccpu_pkg::TIMER_W-1:0] timer;
  ccpu_pkg::ccpu_edge_type      edge_sel;
  logic [ccpu_pkg::TIMER_W-1:0] result;
  logic                         captured;
  modport core (output timer, output edge_sel, input result, input captured);
  modport chan (input timer, input edge_sel, output result, output captured);
endinterface : ccpu_cap_if

// ===== core/ccpu_capture.sv
// one input capture channel: pin sync, edge detect, result latch
`timescale 1ns/1ps
module ccpu_capture (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  ccpu_cap_if.chan  cap
);
  logic sync1;
  logic sync2;
  logic last;
  logic rise;
  logic fall;
  logic hit;

  // two-flop synchroniser plus edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last  <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      last  <= sync2;
    end
  end

  // edge qualification by selected mode
  assign rise = sync2 & ~last;
  assign fall = ~sync2 & last;
  always_comb begin
    unique case (cap.edge_sel)
      ccpu_pkg::CAP_OFF:     hit = 1'b0;
      ccpu_pkg::CAP_RISING:  hit = rise;
      ccpu_pkg::CAP_FALLING: hit = fall;
      ccpu_pkg::CAP_BOTH:    hit = rise | fall;
    endcase
  end

  // R8 independent channel
  // R11 both bytes loaded together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap.result   <= '0;
      cap.captured <= 1'b0;
    end else begin
      cap.captured <= hit;
      if (hit) begin
        cap.result <= cap.timer;
      end
    end
  end
endmodule : ccpu_capture

// ===== core/ccpu_pkg.sv
// constants and types shared by the capture-compare unit
package ccpu_pkg;
  localparam int unsigned TIMER_W  = 16;
  localparam int unsigned NUM_PWM  = 4;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_INVERT   = 8'h04;
  localparam logic [7:0] OFF_FORCE    = 8'h08;
  localparam logic [7:0] OFF_PERIOD   = 8'h0c;
  localparam logic [3:0] OFF_CMP_HI   = 4'h1;   // 0x10..0x1c by paddr[7:4]
  localparam logic [7:0] OFF_CORE_DIV = 8'h20;
  localparam logic [7:0] OFF_PLL_DIV  = 8'h24;
  localparam logic [7:0] OFF_STATUS   = 8'h28;
  localparam logic [7:0] OFF_CAP_CTRL = 8'h2c;
  localparam logic [7:0] OFF_CAPA_LO  = 8'h30;
  localparam logic [7:0] OFF_CAPA_HI  = 8'h34;
  localparam logic [7:0] OFF_CAPB_LO  = 8'h38;
  localparam logic [7:0] OFF_CAPB_HI  = 8'h3c;
  // field positions
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_ALT_BIT  = 1;
  localparam int unsigned CTRL_HALT_BIT = 2;
  localparam int unsigned STAT_HALT_BIT = 0;
  localparam int unsigned STAT_PHASE_BIT = 1;
  localparam int unsigned STAT_DIV0_BIT = 2;
  localparam int unsigned STAT_CAPA_BIT = 3;
  localparam int unsigned STAT_CAPB_BIT = 4;
  // values after reset
  localparam logic [2:0]         RST_CTRL     = 3'h0;
  localparam logic [NUM_PWM-1:0] RST_INVERT   = 4'h0;
  localparam logic [NUM_PWM-1:0] RST_FORCE    = 4'h0;
  localparam logic [TIMER_W-1:0] RST_PERIOD   = 16'hffff;
  localparam logic [TIMER_W-1:0] RST_CMP      = 16'h0000;
  localparam logic [7:0]         RST_CORE_DIV = 8'h00;
  localparam logic [3:0]         RST_PLL_DIV  = 4'h1;
  localparam logic [3:0]         RST_CAP_CTRL = 4'h0;
  // capture edge selection
  typedef enum logic [1:0] {
    CAP_OFF     = 2'b00,
    CAP_RISING  = 2'b01,
    CAP_FALLING = 2'b10,
    CAP_BOTH    = 2'b11
  } ccpu_edge_type;
endpackage : ccpu_pkg

// ===== core/ccpu_top.sv
// capture-compare unit: pwm outputs, two captures, apb registers
//
// Notes on behaviour
// R1 - alternate mode outputs pair alternately
// R2 - every pwm output has own inversion
// R3 - halt forces outputs to force levels
// R4 - inverted inactive alternate level follows inversion
// R5 - software keeps pll input 0.5-1 MHz
// R6 - tick through core and pll dividers
// R7 - software avoids pll divider value zero
// R8 - two independent capture channels a, b
// R9 - results read as low, high bytes
// R10 - high byte read returns current value
// R11 - capture loads both bytes same cycle
`timescale 1ns/1ps
module ccpu_top #(
  parameter int unsigned NUM_PWM = ccpu_pkg::NUM_PWM
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               capture_channel_a,
  input  wire logic               capture_channel_b,
  input  wire logic               halt_in,
  output logic      [NUM_PWM-1:0] pwm_out
);
  localparam int unsigned TW = ccpu_pkg::TIMER_W;

  // elaboration check on the output count
  if (NUM_PWM < 2 || NUM_PWM > 4) begin : g_bad_num_pwm
    $error("NUM_PWM must lie between 2 and 4");
  end

  logic [2:0]         ctrl;
  logic [NUM_PWM-1:0] invert;
  logic [NUM_PWM-1:0] halt_force_level;
  logic [TW-1:0]      period;
  logic [TW-1:0]      cmp [NUM_PWM];
  logic [7:0]         core_clock_divider;
  logic [3:0]         pll_input_divider;
  logic [3:0]         cap_ctrl;
  logic [1:0]         cap_seen;
  logic [7:0]         div_m_cnt;
  logic [3:0]         div_p_cnt;
  logic               tick;
  logic [TW-1:0]      timer;
  logic               phase;
  logic               halt_s1;
  logic               halt_s2;
  logic               halted;
  logic               wr_en;
  logic               rd_en;
  logic               mapped;
  logic [31:0]        next_prdata;
  logic [NUM_PWM-1:0] next_pwm;

  ccpu_cap_if cap_a_if ();
  ccpu_cap_if cap_b_if ();

  // R8 channel a
  ccpu_capture u_cap_a (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (capture_channel_a),
    .cap     (cap_a_if.chan)
  );

  // R8 channel b
  ccpu_capture u_cap_b (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (capture_channel_b),
    .cap     (cap_b_if.chan)
  );

  // timer value and edge mode to channels
  assign cap_a_if.timer    = timer;
  assign cap_b_if.timer    = timer;
  assign cap_a_if.edge_sel = ccpu_pkg::ccpu_edge_type'(cap_ctrl[1:0]);
  assign cap_b_if.edge_sel = ccpu_pkg::ccpu_edge_type'(cap_ctrl[3:2]);

  // apb access phase decode
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;

  // halt pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
    end else begin
      halt_s1 <= halt_in;
      halt_s2 <= halt_s1;
    end
  end
  assign halted = halt_s2 | ctrl[ccpu_pkg::CTRL_HALT_BIT];

  // pready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // control registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl               <= ccpu_pkg::RST_CTRL;
      invert             <= NUM_PWM'(ccpu_pkg::RST_INVERT);
      halt_force_level   <= NUM_PWM'(ccpu_pkg::RST_FORCE);
      period             <= ccpu_pkg::RST_PERIOD;
      core_clock_divider <= ccpu_pkg::RST_CORE_DIV;
      pll_input_divider  <= ccpu_pkg::RST_PLL_DIV;
      cap_ctrl           <= ccpu_pkg::RST_CAP_CTRL;
      for (int i = 0; i < NUM_PWM; i++) begin
        cmp[i] <= ccpu_pkg::RST_CMP;
      end
    end else if (wr_en) begin
      unique case (paddr)
        ccpu_pkg::OFF_CTRL:     ctrl <= pwdata[2:0];
        ccpu_pkg::OFF_INVERT:   invert <= pwdata[NUM_PWM-1:0];
        ccpu_pkg::OFF_FORCE:    halt_force_level <= pwdata[NUM_PWM-1:0];
        ccpu_pkg::OFF_PERIOD:   period <= pwdata[TW-1:0];
        ccpu_pkg::OFF_CORE_DIV: core_clock_divider <= pwdata[7:0];
        ccpu_pkg::OFF_PLL_DIV:  pll_input_divider <= pwdata[3:0];
        ccpu_pkg::OFF_CAP_CTRL: cap_ctrl <= pwdata[3:0];
        default: begin
          if (paddr[7:4] == ccpu_pkg::OFF_CMP_HI
              && 32'(paddr[3:2]) < NUM_PWM) begin
            cmp[paddr[3:2]] <= pwdata[TW-1:0];
          end
        end
      endcase
    end
  end

  // capture seen flags, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_seen <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 ? cap_a_if.captured : cap_b_if.captured)) begin
          cap_seen[i] <= 1'b1;
        end else if (wr_en && paddr == ccpu_pkg::OFF_STATUS
                     && pwdata[ccpu_pkg::STAT_CAPA_BIT + i]) begin
          cap_seen[i] <= 1'b0;
        end
      end
    end
  end

  // R6 core divider then pll input divider give the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_m_cnt <= 8'h00;
      div_p_cnt <= 4'h0;
      tick      <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (div_m_cnt >= core_clock_divider) begin
        div_m_cnt <= 8'h00;
        // R7 zero divider still ticks here, reported in status
        if (div_p_cnt >= pll_input_divider) begin
          div_p_cnt <= 4'h0;
          tick      <= 1'b1;
        end else begin
          div_p_cnt <= div_p_cnt + 4'h1;
        end
      end else begin
        div_m_cnt <= div_m_cnt + 8'h01;
      end
    end
  end

  // timer runs when enabled and not halted; phase flips each period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= '0;
      phase <= 1'b0;
    end else if (!ctrl[ccpu_pkg::CTRL_RUN_BIT]) begin
      timer <= '0;
      phase <= 1'b0;
    end else if (tick && !halted) begin
      if (timer >= period) begin
        timer <= '0;
        phase <= ~phase;
      end else begin
        timer <= timer + TW'(1);
      end
    end
  end

  // pwm levels before the output flops
  always_comb begin
    next_pwm = '0;
    for (int i = 0; i < NUM_PWM; i++) begin
      next_pwm[i] = ctrl[ccpu_pkg::CTRL_RUN_BIT] && (timer < cmp[i]);
    end
    // R1 pair 0/1 alternate, inactive member held at zero
    if (ctrl[ccpu_pkg::CTRL_ALT_BIT]) begin
      next_pwm[0] = next_pwm[0] & ~phase;
      next_pwm[1] = ctrl[ccpu_pkg::CTRL_RUN_BIT] && (timer < cmp[0]) && phase;
    end
    // R2 per-output polarity
    // R4 inactive inverted level is high, not forced low
    next_pwm = next_pwm ^ invert;
    // R3 halt forces preset levels
    if (halted) begin
      next_pwm = halt_force_level;
    end
  end

  // registered pwm outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= '0;
    end else begin
      pwm_out <= next_pwm;
    end
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    mapped      = 1'b1;
    unique case (paddr)
      ccpu_pkg::OFF_CTRL:     next_prdata[2:0] = ctrl;
      ccpu_pkg::OFF_INVERT:   next_prdata[NUM_PWM-1:0] = invert;
      ccpu_pkg::OFF_FORCE:    next_prdata[NUM_PWM-1:0] = halt_force_level;
      ccpu_pkg::OFF_PERIOD:   next_prdata[TW-1:0] = period;
      ccpu_pkg::OFF_CORE_DIV: next_prdata[7:0] = core_clock_divider;
      ccpu_pkg::OFF_PLL_DIV:  next_prdata[3:0] = pll_input_divider;
      ccpu_pkg::OFF_CAP_CTRL: next_prdata[3:0] = cap_ctrl;
      ccpu_pkg::OFF_STATUS: begin
        next_prdata[ccpu_pkg::STAT_HALT_BIT]  = halted;
        next_prdata[ccpu_pkg::STAT_PHASE_BIT] = phase;
        next_prdata[ccpu_pkg::STAT_DIV0_BIT]  = (pll_input_divider == 4'h0);
        next_prdata[ccpu_pkg::STAT_CAPB_BIT:ccpu_pkg::STAT_CAPA_BIT] =
          cap_seen;
      end
      // R9 low and high bytes
      // R10 high byte is the live result
      ccpu_pkg::OFF_CAPA_LO:  next_prdata[7:0] = cap_a_if.result[7:0];
      ccpu_pkg::OFF_CAPA_HI:  next_prdata[7:0] = cap_a_if.result[15:8];
      ccpu_pkg::OFF_CAPB_LO:  next_prdata[7:0] = cap_b_if.result[7:0];
      ccpu_pkg::OFF_CAPB_HI:  next_prdata[7:0] = cap_b_if.result[15:8];
      default: begin
        if (paddr[7:4] == ccpu_pkg::OFF_CMP_HI
            && 32'(paddr[3:2]) < NUM_PWM) begin
          next_prdata[TW-1:0] = cmp[paddr[3:2]];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // read data registered with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= next_prdata;
    end
  end
endmodule : ccpu_top

// ===== tb/ccpu_checker.sv
// port assertions for the capture-compare unit
`timescale 1ns/1ps
module ccpu_checker #(
  parameter int unsigned NUM_PWM = 4
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               halt_in,
  input wire logic [NUM_PWM-1:0] pwm_out
);
  // apb handshake and decode, pwm hold in halt
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  chk_ready_wait: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_decode: assert property (pready |->
    pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h3c))
    else $error("pslverr wrong");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved");
  chk_halt_hold: assert property (halt_in [*6] |-> $stable(pwm_out))
    else $error("pwm moved in halt");
  // main scenarios
  cover property (pslverr && !pwrite);
  cover property (halt_in [*6]);
  cover property ($changed(pwm_out) && !halt_in);
endmodule : ccpu_checker

bind ccpu_top ccpu_checker #(.NUM_PWM(NUM_PWM)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .halt_in(halt_in), .pwm_out(pwm_out));

// ===== tb/ccpu_far.sv
// capture sources and pwm loads at the far side
`timescale 1ns/1ps
module ccpu_far (
  input  wire logic       pclk,
  input  wire logic       pulse_a,
  input  wire logic       pulse_b,
  input  wire logic [3:0] pwm_out,
  output logic            capture_channel_a,
  output logic            capture_channel_b,
  output logic [3:0]      load_level
);
  // each source toggles its line on request
  initial begin
    capture_channel_a = 1'b0;
    capture_channel_b = 1'b0;
  end
  always @(posedge pclk) begin
    if (pulse_a) capture_channel_a <= ~capture_channel_a;
    if (pulse_b) capture_channel_b <= ~capture_channel_b;
  end
  // loads see the pwm levels one cycle late
  always @(posedge pclk) load_level <= pwm_out;
endmodule : ccpu_far

// ===== tb/ccpu_tb.sv
// self-checking bench for the capture-compare unit
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ccpu_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        halt_in, pulse_a, pulse_b, cap_a, cap_b, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, h1;
  logic [3:0]  pwm_out, loads;
  logic [1:0]  seen;
  logic [15:0] va, vb, d;
  int          n_errors, n_compared, cycles;

  ccpu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_channel_a(cap_a), .capture_channel_b(cap_b),
    .halt_in(halt_in), .pwm_out(pwm_out));
  ccpu_far u_far (.pclk(pclk), .pulse_a(pulse_a), .pulse_b(pulse_b),
    .pwm_out(pwm_out), .capture_channel_a(cap_a),
    .capture_channel_b(cap_b), .load_level(loads));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] dw);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dw;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk

  initial begin
    {psel, penable, pwrite, halt_in, pulse_a, pulse_b} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // values after reset, refused places
    rchk(ccpu_pkg::OFF_PERIOD, 32'hffff);
    rchk(ccpu_pkg::OFF_PLL_DIV, 32'h1);
    rchk(ccpu_pkg::OFF_STATUS, 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    `CHK({perr, rd}, 33'h100000000)
    xfer(1'b1, 8'h06, 32'h1);
    `CHK(perr, 1'b1)
    // zero divider only flagged, then avoided
    xfer(1'b1, ccpu_pkg::OFF_PLL_DIV, 32'h0);
    rchk(ccpu_pkg::OFF_STATUS, 32'h4);
    xfer(1'b1, ccpu_pkg::OFF_PLL_DIV, 32'h1);
    xfer(1'b1, ccpu_pkg::OFF_CORE_DIV, 32'h1);
    xfer(1'b1, ccpu_pkg::OFF_PERIOD, 32'h10);
    for (int i = 0; i < 4; i++)
      xfer(1'b1, {ccpu_pkg::OFF_CMP_HI, 2'(i), 2'h0}, 32'hffff);
    xfer(1'b1, ccpu_pkg::OFF_INVERT, 32'h6);
    xfer(1'b1, ccpu_pkg::OFF_CTRL, 32'h1);
    repeat (4) @(negedge pclk);
    `CHK(pwm_out, 4'h9)
    // alternate pair, inverted inactive level high
    xfer(1'b1, ccpu_pkg::OFF_INVERT, 32'h3);
    xfer(1'b1, ccpu_pkg::OFF_CTRL, 32'h3);
    repeat (4) @(negedge pclk);
    seen = 2'h0;
    repeat (300) begin
      @(negedge pclk);
      `CHK(^loads[1:0], 1'b1)
      seen = seen | {loads[1:0] == 2'b01, loads[1:0] == 2'b10};
    end
    `CHK(seen, 2'b11)
    // halt pin, then control bit, force levels
    xfer(1'b1, ccpu_pkg::OFF_CTRL, 32'h1);
    xfer(1'b1, ccpu_pkg::OFF_INVERT, 32'h0);
    xfer(1'b1, ccpu_pkg::OFF_FORCE, 32'ha);
    halt_in <= 1'b1;
    repeat (6) @(negedge pclk);
    `CHK(pwm_out, 4'ha)
    xfer(1'b0, ccpu_pkg::OFF_STATUS, 32'h0);
    `CHK(rd[0], 1'b1)
    halt_in <= 1'b0;
    xfer(1'b1, ccpu_pkg::OFF_FORCE, 32'h5);
    xfer(1'b1, ccpu_pkg::OFF_CTRL, 32'h5);
    repeat (3) @(negedge pclk);
    `CHK(pwm_out, 4'h5)
    xfer(1'b1, ccpu_pkg::OFF_CTRL, 32'h0);
    xfer(1'b1, ccpu_pkg::OFF_CTRL, 32'h1);
    // captures 40 clocks apart, 10 ticks
    xfer(1'b1, ccpu_pkg::OFF_PERIOD, 32'h110);
    xfer(1'b1, ccpu_pkg::OFF_CAP_CTRL, 32'h5);
    // about 258 ticks in, so the high byte is nonzero
    repeat (1024) @(posedge pclk);
    pulse_a <= 1'b1;
    @(posedge pclk) pulse_a <= 1'b0;
    repeat (39) @(posedge pclk);
    pulse_b <= 1'b1;
    @(posedge pclk) pulse_b <= 1'b0;
    repeat (8) @(posedge pclk);
    xfer(1'b0, ccpu_pkg::OFF_CAPA_HI, 32'h0);
    h1 = rd;
    `CHK(h1, 32'h1)
    xfer(1'b0, ccpu_pkg::OFF_CAPA_HI, 32'h0);
    `CHK(rd, h1)
    va[15:8] = h1[7:0];
    xfer(1'b0, ccpu_pkg::OFF_CAPA_LO, 32'h0);
    va[7:0] = rd[7:0];
    `CHK(rd[31:8], 24'h0)
    xfer(1'b0, ccpu_pkg::OFF_CAPB_HI, 32'h0);
    vb[15:8] = rd[7:0];
    xfer(1'b0, ccpu_pkg::OFF_CAPB_LO, 32'h0);
    vb[7:0] = rd[7:0];
    d = (vb >= va) ? vb - va : vb + 16'h111 - va;
    `CHK(d, 16'ha)
    xfer(1'b0, ccpu_pkg::OFF_STATUS, 32'h0);
    `CHK(rd[4:3], 2'b11)
    xfer(1'b1, ccpu_pkg::OFF_STATUS, 32'h18);
    rchk(ccpu_pkg::OFF_CAP_CTRL, 32'h5);
    xfer(1'b0, ccpu_pkg::OFF_STATUS, 32'h0);
    `CHK(rd[4:3], 2'b00)
    test_done();
  end
endmodule : ccpu_tb
